// *** common/spsel_pkg.sv ***
package spsel_pkg;
   // start path state, gray along the coast then brake path
   typedef enum logic [3:0]
   {
      SPSEL_IDLE   = 4'h0,
      SPSEL_CLASS  = 4'h1,
      SPSEL_COAST  = 4'h3,
      SPSEL_BRAKE  = 4'h2,
      SPSEL_METHOD = 4'h6,
      SPSEL_OPEN   = 4'h7,
      SPSEL_CLOSED = 4'h5,
      SPSEL_REVDRV = 4'h4
   } spsel_state_t;
   // avalon request bundle
   typedef struct packed
   {
      logic [7:0]  address;
      logic        read;
      logic        write;
      logic [31:0] writedata;
   } spsel_av_req_t;
   // rotor state seen at start
   typedef struct packed
   {
      logic        spinning;
      logic        dir_fwd;
      logic [15:0] bemf;
   } spsel_rotor_t;
endpackage

// *** common/spsel_regs.svh ***
`ifndef SPSEL_REGS_SVH
`define SPSEL_REGS_SVH
// register byte offsets
`define SPSEL_CTRL_OFS      8'h00
`define SPSEL_THR_OFS       8'h04
`define SPSEL_FREQ_OFS      8'h08
`define SPSEL_SERIAL_OFS    8'h0C
`define SPSEL_START_OFS     8'h10
`define SPSEL_STATUS_OFS    8'h14
`define SPSEL_DUTY_OFS      8'h18
// ctrl field positions
`define SPSEL_CTRL_SRC_LSB    0
`define SPSEL_CTRL_RANGE_LSB  2
`define SPSEL_CTRL_OUTF_LSB   4
`define SPSEL_CTRL_CATCH_BIT  8
`define SPSEL_CTRL_RVS_BIT    9
`define SPSEL_CTRL_COAST_BIT  10
`define SPSEL_CTRL_BRAKE_BIT  11
`define SPSEL_CTRL_PREBRK_BIT 12
`define SPSEL_CTRL_METH_LSB   13
// reset values
`define SPSEL_CTRL_RST      32'h0000_0001
`define SPSEL_THR_RST       32'h0000_0000
`define SPSEL_FREQ_RST      32'h0000_0000
`define SPSEL_START_RST     32'h0000_0000
// speed source codes
`define SPSEL_SRC_PWM       2'h1
`define SPSEL_SRC_SERIAL    2'h2
`define SPSEL_SRC_FREQ      2'h3
// timing and full scale duty
`define SPSEL_COAST_PWM_CYC 200000
`define SPSEL_DUTY_FULL     16'hFFFF
`endif

// *** dv/spsel_host_model.sv ***
// ----------------------------------------
// host side speed pin source
// ----------------------------------------
module spsel_host_model
(
   input  wire logic        sys_clk,  // bench clock
   input  wire logic        run,      // produce the square wave
   input  wire logic [15:0] high_cyc, // high time in clock cycles
   input  wire logic [15:0] low_cyc,  // low time in clock cycles
   output logic             speed_pin // speed pin level
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] cnt_reg; // cycles spent in the current phase
   initial speed_pin = 1'b0;
   initial cnt_reg = 16'h0;
   // square wave; idle low, so a stopped host reads as below sleep entry
   // low_cyc stays above the sleep delay the bench programs
   always @(posedge sys_clk)
   begin
      if (!run)
      begin
         speed_pin <= 1'b0;
         cnt_reg   <= 16'h0;
      end
      else if (cnt_reg + 16'h1 >= (speed_pin ? high_cyc : low_cyc))
      begin
         speed_pin <= ~speed_pin; // phase over, flip the pin
         cnt_reg   <= 16'h0;
      end
      else
         cnt_reg <= cnt_reg + 16'h1;
   end
endmodule // spsel_host_model

// *** dv/testbench.sv ***
`include "spsel_regs.svh"
module testbench;
   import spsel_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // stimulus and observed signals
   // ----------------------------------------
   logic          sys_clk = 1'b0;   // 100 MHz
   logic          reset = 1'b1;     // sync, active high
   spsel_av_req_t av_req = '0;      // bus request
   logic [31:0]   av_readdata;      // read data
   logic          av_waitrequest;   // bus stall
   logic          speed_pin;        // from host model
   logic          above = 1'b0;     // pin above sleep exit
   logic          below = 1'b0;     // pin below sleep entry
   logic          start_req = 1'b0; // start path request
   logic          tick = 1'b0;      // output pwm cycle pulse
   logic          done = 1'b0;      // start method finished
   logic          zc = 1'b0;        // reverse decel at zero
   spsel_rotor_t  rotor = '0;       // rotor at start
   logic [15:0]   duty_cmd;         // duty command
   logic          sleep_out;        // asleep
   logic          standby_out;      // standby
   logic          low_sides_on;     // brake drive
   logic [1:0]    start_method;     // stationary method
   logic [3:0]    out_freq_sel;     // output frequency select
   logic [3:0]    state_out;        // start path state
   logic          run = 1'b0;       // host waveform on
   logic [15:0]   hi_c = 16'h32;    // host high time
   logic [15:0]   lo_c = 16'h32;    // host low time
   logic [1:0]    tdiv = 2'h0;      // tick divider
   int            miscompares = 0;  // mismatches
   int            n_tests = 0;      // comparisons
   int            cyc = 0;          // cycles run
   int            brk_len = 0;      // cycles with brake on
   always #5 sys_clk = ~sys_clk;
   // an output pwm cycle every four clocks keeps the coast timeout short
   always @(posedge sys_clk)
   begin
      tdiv <= tdiv + 2'h1;
      tick <= (tdiv == 2'h3);
      if (low_sides_on === 1'b1)
         brk_len <= brk_len + 1;
      cyc <= cyc + 1;
      if (cyc == 40000)
      begin
         miscompares++; // hang: count it and close
         wrap_up();
      end
   end
   spsel_host_model u_host (.sys_clk(sys_clk), .run(run), .high_cyc(hi_c), .low_cyc(lo_c),
      .speed_pin(speed_pin));
   spsel_core #(.COAST_CYCLES(5)) u_dut (.sys_clk(sys_clk), .reset(reset), .av_req(av_req),
      .av_readdata(av_readdata), .av_waitrequest(av_waitrequest), .speed_pin(speed_pin),
      .pin_above_exit(above), .pin_below_entry(below), .start_req(start_req),
      .pwm_out_tick(tick), .method_done(done), .zero_cross(zc), .rotor(rotor),
      .duty_cmd(duty_cmd), .sleep_out(sleep_out), .standby_out(standby_out),
      .low_sides_on(low_sides_on), .start_method(start_method),
      .out_freq_sel(out_freq_sel), .state_out(state_out));
   // ----------------------------------------
   // compares and bus cycles
   // ----------------------------------------
   task chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e)
      begin
         miscompares++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   // window compare; an unknown never lands inside
   task chk_rng(input string nm, input logic [31:0] lo, input logic [31:0] hi,
      input logic [31:0] g);
      n_tests++;
      if (((g >= lo) && (g <= hi)) !== 1'b1)
      begin
         miscompares++;
         $display("BAD %s exp %h..%h got %h", nm, lo, hi, g);
      end
   endtask
   // hold the request until waitrequest is sampled low, take data there
   task av_xfer(input logic rd, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
      @(posedge sys_clk);
      av_req <= {a, rd, ~rd, d};
      do
         @(posedge sys_clk);
      while (av_waitrequest !== 1'b0);
      q = av_readdata;
      av_req <= {a, 2'b00, d};
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      av_xfer(1'b0, a, d, q);
   endtask
   task rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      av_xfer(1'b1, a, 32'h0, q);
      chk_val(nm, e, q);
   endtask
   // let a few host periods pass, then judge the duty command
   task duty_after(input string nm, input int n, input logic [31:0] lo, input logic [31:0] hi);
      repeat (n) @(posedge speed_pin);
      repeat (3) @(posedge sys_clk);
      chk_rng(nm, lo, hi, {16'h0, duty_cmd});
   endtask
   task wait_state(input logic [3:0] want, input int lim);
      int i;
      for (i = 0; i < lim && state_out !== want; i++)
         @(posedge sys_clk);
      chk_val("state", {28'h0, want}, {28'h0, state_out});
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task t_regs;
      rd_chk("ctrl", `SPSEL_CTRL_OFS, `SPSEL_CTRL_RST);
      rd_chk("thr", `SPSEL_THR_OFS, `SPSEL_THR_RST);
      rd_chk("freq", `SPSEL_FREQ_OFS, `SPSEL_FREQ_RST);
      rd_chk("start", `SPSEL_START_OFS, `SPSEL_START_RST);
      wr(8'h1C, 32'hFFFF_FFFF); // unmapped write is dropped
      rd_chk("unmapped", 8'h1C, 32'h0);
   endtask
   task t_pwm;
      wr(`SPSEL_THR_OFS, 32'h0100_1000);
      wr(`SPSEL_START_OFS, 32'h0008_0014);
      wr(`SPSEL_CTRL_OFS, 32'h0000_00A5); // range 1, out freq A
      run <= 1'b1;
      duty_after("duty50", 3, 32'h7DFF, 32'h81FF);
      chk_val("outf", 32'hA, {28'h0, out_freq_sel});
      @(posedge sys_clk);
      hi_c <= 16'h2;
      lo_c <= 16'h62;
      duty_after("duty2", 3, 32'h0, 32'h0);
   endtask
   task t_freq;
      wr(`SPSEL_FREQ_OFS, 32'h00C8_1000);
      wr(`SPSEL_CTRL_OFS, 32'h0000_0003);
      hi_c <= 16'h32;
      lo_c <= 16'h32;
      duty_after("fclamp", 3, 32'hFFFF, 32'hFFFF);
      hi_c <= 16'hC8;
      lo_c <= 16'hC8;
      duty_after("fhalf", 3, 32'h7DFF, 32'h81FF);
      hi_c <= 16'h7D0;
      lo_c <= 16'h7D0;
      duty_after("fstby", 3, 32'h0, 32'h0);
   endtask
   task t_serial;
      run <= 1'b0;
      above <= 1'b1;
      wr(`SPSEL_CTRL_OFS, 32'h0000_0002);
      wr(`SPSEL_SERIAL_OFS, 32'h0000_4000);
      repeat (4) @(posedge sys_clk);
      chk_val("sduty", 32'h4000, {16'h0, duty_cmd});
      wr(`SPSEL_SERIAL_OFS, 32'h0000_0080);
      repeat (4) @(posedge sys_clk);
      chk_val("stby", 32'h1, {31'h0, standby_out});
      wr(`SPSEL_SERIAL_OFS, 32'h0000_0000);
      above <= 1'b0;
      below <= 1'b1;
      repeat (8) @(posedge sys_clk);
      chk_val("early", 32'h0, {31'h0, sleep_out});
      repeat (30) @(posedge sys_clk);
      chk_val("sleep", 32'h1, {31'h0, sleep_out});
      rd_chk("status", `SPSEL_STATUS_OFS, 32'h0000_0020);
      above <= 1'b1;
      below <= 1'b0;
      wr(`SPSEL_SERIAL_OFS, 32'h0000_2000);
      repeat (4) @(posedge sys_clk);
      chk_val("wake", 32'h0, {31'h0, sleep_out});
      chk_val("wduty", 32'h2000, {16'h0, duty_cmd});
   endtask
   // ctrl keeps the pwm source; the host runs at half duty meanwhile
   task start_case(input logic [31:0] c, input spsel_rotor_t r, input logic [3:0] first);
      wr(`SPSEL_CTRL_OFS, c);
      run <= 1'b1;
      rotor <= r;
      brk_len <= 0;
      start_req <= 1'b1;
      wait_state(first, 50);
   endtask
   task pulse(input logic sel);
      @(posedge sys_clk);
      if (sel)
         done <= 1'b1;
      else
         zc <= 1'b1;
      @(posedge sys_clk);
      done <= 1'b0;
      zc <= 1'b0;
   endtask
   task stop_case;
      @(posedge sys_clk);
      start_req <= 1'b0;
      wait_state(SPSEL_IDLE, 20);
   endtask
   task t_start;
      hi_c <= 16'h32;
      lo_c <= 16'h32;
      start_case(32'h0000_5001, '{1'b0, 1'b1, 16'h0}, SPSEL_METHOD);
      chk_rng("brake", 32'h7, 32'h9, brk_len);
      chk_val("meth", 32'h2, {30'h0, start_method});
      pulse(1'b1);
      wait_state(SPSEL_OPEN, 10);
      stop_case();
      start_case(32'h0000_0101, '{1'b1, 1'b1, 16'hFFFF}, SPSEL_CLOSED);
      stop_case();
      start_case(32'h0000_0201, '{1'b1, 1'b0, 16'hFFFF}, SPSEL_REVDRV);
      pulse(1'b0);
      wait_state(SPSEL_OPEN, 10);
      stop_case();
      start_case(32'h0000_1C01, '{1'b1, 1'b1, 16'hFFFF}, SPSEL_COAST);
      repeat (10) @(posedge sys_clk);
      wait_state(SPSEL_COAST, 1);
      wait_state(SPSEL_METHOD, 200);
      chk_rng("cbrake", 32'h7, 32'h9, brk_len);
      stop_case();
      start_case(32'h0000_0401, '{1'b1, 1'b0, 16'hFFFF}, SPSEL_COAST);
      rotor <= '{1'b1, 1'b0, 16'h0010};
      wait_state(SPSEL_METHOD, 6);
      stop_case();
   endtask
   task wrap_up;
      $display("tests %0d miscompares %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      repeat (10) @(posedge sys_clk);
      reset <= 1'b0;
      t_regs();
      t_pwm();
      t_freq();
      t_serial();
      t_start();
      wrap_up();
   end
endmodule // testbench

// *** rtl/spsel_core.sv ***
// Design decisions made here: the placing of the registers and register access over Avalon-MM.
`include "spsel_regs.svh"
//
// Function
// RQ1: pwm code selects duty input
// RQ2: duty follows input duty, standby zero
// RQ3: range select scales accepted pwm period
// RQ4: output frequency has separate setting
// RQ5: host sets sleep delay above low time
// RQ6: serial code selects register speed
// RQ7: duty derived from serial command register
// RQ8: sleep when zero long and pin low
// RQ9: pin high leaves sleep, serial resumes
// RQ10: standby while serial low, pin high
// RQ11: frequency code selects frequency input
// RQ12: duty linear in frequency, standby zero
// RQ13: above full scale frequency clamps full
// RQ14: direction classified against commanded direction
// RQ15: stationary runs configured method then open
// RQ16: optional brake before stationary method
// RQ17: forward spin catch goes closed loop
// RQ18: no catch: coast/brake then stationary
// RQ19: reverse drive decelerates through zero
// RQ20: no reverse drive: coast/brake then stationary
// RQ21: coast ends on low bemf or timeout
// RQ22: brake turns on all low sides
// RQ23: count high, low, period; update per period (only high time and period are counted here; low time is not)
module spsel_core
   import spsel_pkg::*;
#(
   parameter int COAST_CYCLES = `SPSEL_COAST_PWM_CYC  // output pwm cycles before coast gives up
)
(
   input  wire logic           sys_clk,        // 100 MHz clock
   input  wire logic           reset,          // synchronous, active high
   input  wire spsel_av_req_t  av_req,         // avalon request
   output logic [31:0]         av_readdata,    // read data
   output logic                av_waitrequest, // low at accepting edge
   input  wire logic           speed_pin,      // digital speed pin level
   input  wire logic           pin_above_exit, // pin above sleep exit level
   input  wire logic           pin_below_entry,// pin below sleep entry level
   input  wire logic           start_req,      // begin start-up
   input  wire logic           pwm_out_tick,   // one per output pwm cycle
   input  wire logic           method_done,    // start method finished
   input  wire logic           zero_cross,     // reverse decel reached zero
   input  wire spsel_rotor_t   rotor,          // initial rotor state
   output logic [15:0]         duty_cmd,       // duty command, full = FFFF
   output logic                sleep_out,      // device asleep
   output logic                standby_out,    // device in standby
   output logic                low_sides_on,   // all three low sides on
   output logic [1:0]          start_method,   // configured stationary method
   output logic [3:0]          out_freq_sel,   // output switching frequency select
   output logic [3:0]          state_out       // start path state
);
   //----------------------------------------------------------------
   // registers
   //----------------------------------------------------------------
   logic [31:0]  ctrl_reg;     // source, range, options
   logic [31:0]  thr_reg;      // duty entry [15:0], serial threshold [31:16]
   logic [31:0]  freq_reg;     // freq entry [15:0], full scale period [31:16]
   logic [15:0]  serial_reg;   // serial speed command
   logic [31:0]  start_reg;    // sleep delay [15:0], brake time [31:16]
   logic         wait_reg;     // waitrequest, high unless answering
   logic [1:0]   src;          // speed source
   assign src = ctrl_reg[`SPSEL_CTRL_SRC_LSB +: 2];
   // every access takes one wait cycle so waitrequest comes from a flop
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         ctrl_reg    <= `SPSEL_CTRL_RST;
         thr_reg     <= `SPSEL_THR_RST;
         freq_reg    <= `SPSEL_FREQ_RST;
         serial_reg  <= 16'h0000;
         start_reg   <= `SPSEL_START_RST;
      end
      else if (av_req.write && !wait_reg)
      begin
         case (av_req.address)
            `SPSEL_CTRL_OFS:   ctrl_reg   <= av_req.writedata;  // RQ1 RQ4
            `SPSEL_THR_OFS:    thr_reg    <= av_req.writedata;
            `SPSEL_FREQ_OFS:   freq_reg   <= av_req.writedata;
            `SPSEL_SERIAL_OFS: serial_reg <= av_req.writedata[15:0]; // RQ7
            `SPSEL_START_OFS:  start_reg  <= av_req.writedata;
            default:           ;  // unmapped writes are dropped
         endcase
      end
   end
   // read path
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         wait_reg    <= 1'b1;
         av_readdata <= 32'h0000_0000;
      end
      else
      begin
         wait_reg    <= !((av_req.read || av_req.write) && wait_reg);
         case (av_req.address)
            `SPSEL_CTRL_OFS:   av_readdata <= ctrl_reg;
            `SPSEL_THR_OFS:    av_readdata <= thr_reg;
            `SPSEL_FREQ_OFS:   av_readdata <= freq_reg;
            `SPSEL_SERIAL_OFS: av_readdata <= {16'h0000, serial_reg};
            `SPSEL_START_OFS:  av_readdata <= start_reg;
            `SPSEL_STATUS_OFS: av_readdata <= {26'h0, sleep_out, standby_out, state_out};
            `SPSEL_DUTY_OFS:   av_readdata <= {16'h0000, duty_cmd};
            default:           av_readdata <= 32'h0000_0000;  // unmapped reads zero
         endcase
      end
   end
   assign av_waitrequest = wait_reg;
   //----------------------------------------------------------------
   // speed pin measurement
   //----------------------------------------------------------------
   logic [23:0] cnt_reg;      // cycles since rising edge
   logic [23:0] high_reg;     // high time of current period
   logic [23:0] per_reg;      // last full period
   logic [23:0] hi_lat_reg;   // last full high time
   logic        pin_d_reg;    // previous pin level
   logic        upd_reg;      // one cycle after period completes
   logic        rise;         // rising edge seen
   logic [23:0] range_max;    // longest accepted period
   assign rise = speed_pin && !pin_d_reg;
   // range select shifts the accepted period window
   assign range_max = 24'h00FFFF << (ctrl_reg[`SPSEL_CTRL_RANGE_LSB +: 2] * 2); // RQ3
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         pin_d_reg  <= 1'b0;
         cnt_reg    <= 24'h000000;
         high_reg   <= 24'h000000;
         per_reg    <= 24'h000000;
         hi_lat_reg <= 24'h000000;
         upd_reg    <= 1'b0;
      end
      else
      begin
         pin_d_reg <= speed_pin;
         upd_reg   <= rise;
         if (rise)
         begin
            per_reg    <= cnt_reg;       // RQ23
            hi_lat_reg <= high_reg;
            cnt_reg    <= 24'h000001;
            high_reg   <= 24'h000001;
         end
         else if (cnt_reg < range_max)
         begin
            cnt_reg  <= cnt_reg + 24'h000001;
            high_reg <= high_reg + {23'h0, speed_pin};
         end
         else
         begin
            // no edge within range: treat as dc level
            per_reg    <= range_max;
            hi_lat_reg <= speed_pin ? range_max : 24'h000000;
         end
      end
   end
   //----------------------------------------------------------------
   // duty command
   //----------------------------------------------------------------
   logic [15:0] in_duty;    // measured duty, full = FFFF
   logic [15:0] freq_duty;  // frequency scaled duty
   logic [39:0] dnum;       // duty numerator
   logic [39:0] fnum;       // frequency numerator
   logic [23:0] fs_per;     // full scale period
   assign dnum   = {hi_lat_reg, 16'h0000};
   assign in_duty = (per_reg == 24'h0) ? 16'h0000 :
                    (hi_lat_reg >= per_reg) ? `SPSEL_DUTY_FULL :
                    16'(dnum / {16'h0, per_reg});
   assign fs_per = {8'h00, freq_reg[31:16]};
   assign fnum   = {fs_per, 16'hFFFF};
   // duty = full scale period / measured period, so linear in frequency
   assign freq_duty = (per_reg == 24'h0 || per_reg >= range_max) ? 16'h0000 :
                      (per_reg <= fs_per) ? `SPSEL_DUTY_FULL :  // RQ13
                      16'(fnum / {16'h0, per_reg});              // RQ12
   always_ff @(posedge sys_clk)
   begin
      if (reset)
         duty_cmd <= 16'h0000;
      else
      begin
         case (src)
            `SPSEL_SRC_PWM:                                      // RQ1
               if (upd_reg)
                  duty_cmd <= (in_duty <= thr_reg[15:0]) ? 16'h0000 : in_duty; // RQ2
            `SPSEL_SRC_SERIAL:                                   // RQ6
               duty_cmd <= (serial_reg <= thr_reg[31:16] || sleep_out) ?
                           16'h0000 : serial_reg;                // RQ7
            `SPSEL_SRC_FREQ:                                     // RQ11
               if (upd_reg)
                  duty_cmd <= (freq_duty <= freq_reg[15:0]) ? 16'h0000 : freq_duty; // RQ12
            default:
               duty_cmd <= 16'h0000;  // analog path lives elsewhere
         endcase
      end
   end
   //----------------------------------------------------------------
   // sleep and standby in serial mode
   //----------------------------------------------------------------
   logic [15:0] zero_cnt_reg;  // cycles serial command has been zero
   logic        zero_long;     // zero longer than sleep delay
   assign zero_long = zero_cnt_reg > start_reg[15:0];
   // host must keep the delay above the pwm low time, else false sleeps
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         zero_cnt_reg <= 16'h0000;
         sleep_out    <= 1'b0;
         standby_out  <= 1'b0;
      end
      else
      begin
         if (serial_reg != 16'h0000)
            zero_cnt_reg <= 16'h0000;
         else if (!zero_long)
            zero_cnt_reg <= zero_cnt_reg + 16'h0001;
         if (src != `SPSEL_SRC_SERIAL)
            sleep_out <= 1'b0;
         else if (sleep_out && pin_above_exit)
            sleep_out <= 1'b0;                       // RQ9
         else if (zero_long && pin_below_entry)
            sleep_out <= 1'b1;                       // RQ8 RQ5
         standby_out <= (src == `SPSEL_SRC_SERIAL) && !sleep_out &&
                        pin_above_exit && (serial_reg <= thr_reg[31:16]); // RQ10
      end
   end
   //----------------------------------------------------------------
   // start path selection
   //----------------------------------------------------------------
   spsel_state_t state_reg;    // start path state
   logic [17:0]  coast_reg;    // output pwm cycles coasted
   logic [15:0]  brk_reg;      // brake cycles left
   logic         fwd;          // rotor matches commanded direction
   assign fwd = rotor.dir_fwd; // RQ14
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         state_reg    <= SPSEL_IDLE;
         coast_reg    <= 18'h00000;
         brk_reg      <= 16'h0000;
         low_sides_on <= 1'b0;
      end
      else if (!start_req && state_reg != SPSEL_IDLE)
      begin
         // dropping the request aborts any start path at once
         state_reg    <= SPSEL_IDLE;
         low_sides_on <= 1'b0;
      end
      else
      begin
         case (state_reg)
            SPSEL_IDLE:
               if (start_req)
                  state_reg <= SPSEL_CLASS;
            SPSEL_CLASS:
            begin
               coast_reg <= 18'h00000;
               if (!rotor.spinning)
                  state_reg <= SPSEL_METHOD;
               else if (fwd && ctrl_reg[`SPSEL_CTRL_CATCH_BIT])
                  state_reg <= SPSEL_CLOSED;          // RQ17
               else if (!fwd && ctrl_reg[`SPSEL_CTRL_RVS_BIT])
                  state_reg <= SPSEL_REVDRV;          // RQ19
               else if (ctrl_reg[`SPSEL_CTRL_COAST_BIT])
                  state_reg <= SPSEL_COAST;           // RQ18 RQ20
               else
                  state_reg <= SPSEL_METHOD;
               if (rotor.spinning || ctrl_reg[`SPSEL_CTRL_PREBRK_BIT])
                  brk_reg <= start_reg[31:16];
               if ((!rotor.spinning && ctrl_reg[`SPSEL_CTRL_PREBRK_BIT]) ||
                   (rotor.spinning && !ctrl_reg[`SPSEL_CTRL_COAST_BIT] &&
                    ctrl_reg[`SPSEL_CTRL_BRAKE_BIT] &&
                    !(fwd && ctrl_reg[`SPSEL_CTRL_CATCH_BIT]) &&
                    !(!fwd && ctrl_reg[`SPSEL_CTRL_RVS_BIT])))
                  state_reg <= SPSEL_BRAKE;           // RQ16
            end
            SPSEL_COAST:
            begin
               if (pwm_out_tick)
                  coast_reg <= coast_reg + 18'h00001;
               if (rotor.bemf < thr_reg[15:0] ||
                   int'(coast_reg) >= COAST_CYCLES)       // RQ21
                  state_reg <= ctrl_reg[`SPSEL_CTRL_BRAKE_BIT] ? SPSEL_BRAKE : SPSEL_METHOD;
            end
            SPSEL_BRAKE:
            begin
               low_sides_on <= brk_reg != 16'h0000;   // RQ22
               if (brk_reg == 16'h0000)
                  state_reg <= SPSEL_METHOD;
               else
                  brk_reg <= brk_reg - 16'h0001;
            end
            SPSEL_METHOD:
            begin
               low_sides_on <= 1'b0;
               if (method_done)
                  state_reg <= SPSEL_OPEN;             // RQ15
            end
            SPSEL_REVDRV:
               if (zero_cross)
                  state_reg <= SPSEL_OPEN;             // RQ19
            SPSEL_OPEN, SPSEL_CLOSED:
               if (!start_req)
                  state_reg <= SPSEL_IDLE;
            default:
               state_reg <= SPSEL_IDLE;
         endcase
      end
   end
   assign state_out    = state_reg;
   assign start_method = ctrl_reg[`SPSEL_CTRL_METH_LSB +: 2];  // RQ15
   assign out_freq_sel = ctrl_reg[`SPSEL_CTRL_OUTF_LSB +: 4];  // RQ4
   //----------------------------------------------------------------
   // assertions
   //----------------------------------------------------------------
   a_brake_low_sides: assert property (@(posedge sys_clk) disable iff (reset)
      low_sides_on |-> $past(state_reg) == SPSEL_BRAKE)        // RQ22
      else $error("low sides on outside brake");
   a_sleep_needs_serial: assert property (@(posedge sys_clk) disable iff (reset)
      $rose(sleep_out) |-> $past(zero_long && pin_below_entry)) // RQ8
      else $error("sleep entered without cause");
   a_sleep_exit_pin: assert property (@(posedge sys_clk) disable iff (reset)
      $fell(sleep_out) |-> $past(pin_above_exit) || $past(src) != `SPSEL_SRC_SERIAL) // RQ9
      else $error("sleep left without pin high");
   a_catch_closed: assert property (@(posedge sys_clk) disable iff (reset)
      start_req && state_reg == SPSEL_CLASS && rotor.spinning && fwd &&
      ctrl_reg[`SPSEL_CTRL_CATCH_BIT]
      |=> state_reg == SPSEL_CLOSED)                           // RQ17
      else $error("spin catch did not go closed loop");
   a_serial_duty: assert property (@(posedge sys_clk) disable iff (reset)
      src == `SPSEL_SRC_SERIAL && $stable(src) && serial_reg > thr_reg[31:16] && !sleep_out
      && $stable(serial_reg) |=> duty_cmd == $past(serial_reg)) // RQ7
      else $error("serial duty mismatch");
   a_pwm_standby: assert property (@(posedge sys_clk) disable iff (reset)
      src == `SPSEL_SRC_PWM && upd_reg && in_duty <= thr_reg[15:0] |=> duty_cmd == 16'h0000) // RQ2
      else $error("duty not zero at standby");
   a_freq_clamp: assert property (@(posedge sys_clk) disable iff (reset)
      src == `SPSEL_SRC_FREQ && upd_reg && per_reg != 24'h0 && per_reg <= fs_per
      && freq_reg[15:0] != 16'hFFFF |=> duty_cmd == `SPSEL_DUTY_FULL) // RQ13
      else $error("frequency not clamped");
   a_method_open: assert property (@(posedge sys_clk) disable iff (reset)
      start_req && state_reg == SPSEL_METHOD && method_done |=> state_reg == SPSEL_OPEN) // RQ15
      else $error("method did not enter open loop");
   c_brake: cover property (@(posedge sys_clk) disable iff (reset) low_sides_on);
   c_sleep: cover property (@(posedge sys_clk) disable iff (reset) $rose(sleep_out));
   c_revdrv: cover property (@(posedge sys_clk) disable iff (reset) state_reg == SPSEL_REVDRV);
endmodule // spsel_core
